// *** rtl/dsaf_top.sv ***
// DDR secure address filter: register file, gate keeper and two filter paths
// How it works
// [R01] Every DDR read and write is checked against up to nine regions.
// [R02] Two filter units check their own paths concurrently.
// [R03] Region 0 is always on and covers all addresses.
// [R04] Regions 1 to 8 hold programmable start and end addresses.
// [R05] Each programmable region attaches to filter 0, filter 1 or both.
// [R06] Per-region secure and non-secure read/write permissions decide access.
// [R07] Non-secure accesses also need their master id enabled in the region.
// [R08] Software must not overlap regions attached to the same filter.
// [R09] Refusal gives bus error, interrupt or both, by fail mode.
// [R10] Up to 256 accepted, uncompleted transactions per filter.
// [R11] Gate keeper opens or closes each filter independently.
// [R12] Only secure register accesses may change the configuration.
// [R13] Refused accesses never reach memory; permitted ones pass unchanged.
// [R14] A programmable region overrides region 0 where both match.
`timescale 1ns/1ps
module dsaf_top
  import dsaf_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  // AHB-Lite register slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic hnonsec_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Upstream request per filter
  input wire logic [dsaf_pkg::NFILT-1:0] up_valid_i,
  output logic [dsaf_pkg::NFILT-1:0] up_ready_o,
  input wire logic [dsaf_pkg::NFILT-1:0][31:0] up_addr_i,
  input wire logic [dsaf_pkg::NFILT-1:0] up_write_i,
  input wire logic [dsaf_pkg::NFILT-1:0] up_nonsec_i,
  input wire logic [dsaf_pkg::NFILT-1:0][dsaf_pkg::ID_W-1:0] up_id_i,
  input wire logic [dsaf_pkg::NFILT-1:0][31:0] up_wdata_i,
  // Upstream response per filter
  output logic [dsaf_pkg::NFILT-1:0] up_rsp_valid_o,
  output logic [dsaf_pkg::NFILT-1:0] up_rsp_err_o,
  output logic [dsaf_pkg::NFILT-1:0][31:0] up_rsp_rdata_o,
  // Downstream to the memory controller
  output logic [dsaf_pkg::NFILT-1:0] dn_valid_o,
  input wire logic [dsaf_pkg::NFILT-1:0] dn_ready_i,
  output logic [dsaf_pkg::NFILT-1:0][31:0] dn_addr_o,
  output logic [dsaf_pkg::NFILT-1:0] dn_write_o,
  output logic [dsaf_pkg::NFILT-1:0][31:0] dn_wdata_o,
  input wire logic [dsaf_pkg::NFILT-1:0] dn_rsp_valid_i,
  input wire logic [dsaf_pkg::NFILT-1:0][31:0] dn_rdata_i,
  output logic irq_o
);
  import dsaf_pkg::*;

  typedef struct packed {
    logic [NFILT-1:0] gate;
    logic [1:0] fmode;
    logic [NFILT-1:0] ist;
    logic [NFILT-1:0] imask;
    logic [NFILT-1:0][31:0] faddr;
    logic [NREG-1:1][31:0] rstart;
    logic [NREG-1:1][31:0] rend;
    logic [NREG-1:0][31:0] rattr;
    logic a_v;
    logic a_wr;
    logic [11:0] a_addr;
    logic [31:0] hrdata;
    logic [NFILT-1:0] slot_v;
    logic [NFILT-1:0][31:0] slot_addr;
    logic [NFILT-1:0] slot_wr;
    logic [NFILT-1:0][31:0] slot_wdata;
    logic [NFILT-1:0][CNT_W-1:0] cnt;
    logic [NFILT-1:0] rsp_v;
    logic [NFILT-1:0] rsp_err;
    logic [NFILT-1:0][31:0] rsp_rdata;
  } dsaf_state_t;

  dsaf_state_t state_r;
  dsaf_state_t state_nxt;
  logic [NFILT-1:0] allow;
  logic [NFILT-1:0] up_fire;

  dsaf_cfg_if cfg ();

  assign cfg.rstart = state_r.rstart;
  assign cfg.rend = state_r.rend;
  assign cfg.rattr = state_r.rattr;

  generate
    for (genvar f = 0; f < NFILT; f++)
    begin : g_filt
      dsaf_check #(.FILTER(f)) u_check ( // [R02]
        .addr_i(up_addr_i[f]),
        .write_i(up_write_i[f]),
        .nonsec_i(up_nonsec_i[f]),
        .id_i(up_id_i[f]),
        .cfg(cfg.chk),
        .allow_o(allow[f])
      );
    end
  endgenerate

  // Register read decode, used at every secure address phase
  function automatic logic [31:0] reg_read(input dsaf_state_t s,
                                           input logic [11:0] a);
    logic [31:0] d;
    logic [3:0] idx;
    d = 32'h0000_0000;
    idx = a[7:4];
    case (a)
      OFS_GATE: d[NFILT-1:0] = s.gate;
      OFS_FMODE: d[1:0] = s.fmode;
      OFS_ISTAT: d[NFILT-1:0] = s.ist;
      OFS_IMASK: d[NFILT-1:0] = s.imask;
      OFS_FADDR0: d = s.faddr[0];
      OFS_FADDR1: d = s.faddr[1];
      OFS_COUNT: d = {7'h00, s.cnt[1], 7'h00, s.cnt[0]};
      default:
      begin
        if (a[11:8] == REGION_PAGE && idx < 4'(NREG))
        begin
          if (idx == 4'h0)
          begin
            if (a[3:2] == FLD_START)
              d = R0_START;
            else if (a[3:2] == FLD_END)
              d = R0_END;
            else if (a[3:2] == FLD_ATTR)
              d = s.rattr[0];
          end
          else if (a[3:2] == FLD_START)
            d = s.rstart[idx];
          else if (a[3:2] == FLD_END)
            d = s.rend[idx];
          else if (a[3:2] == FLD_ATTR)
            d = s.rattr[idx];
        end
      end
    endcase
    return d;
  endfunction

  // Acceptance: open gate, free slot, and room or an empty pipe
  always_comb
  begin
    for (int f = 0; f < NFILT; f++)
    begin
      if (allow[f])
        up_ready_o[f] = state_r.gate[f] && !state_r.slot_v[f] && // [R11]
                        state_r.cnt[f] < MAX_OUTSTANDING; // [R10]
      else
        up_ready_o[f] = state_r.gate[f] && !state_r.slot_v[f] &&
                        state_r.cnt[f] == CNT_ZERO;
      up_fire[f] = up_valid_i[f] && up_ready_o[f];
    end
  end

  always_comb
  begin
    state_nxt = state_r;

    // Register write in the data phase; non-secure writes were dropped
    if (state_r.a_v && state_r.a_wr)
    begin
      case (state_r.a_addr)
        OFS_GATE: state_nxt.gate = hwdata_i[NFILT-1:0]; // [R11]
        OFS_FMODE: state_nxt.fmode = hwdata_i[1:0]; // [R09]
        OFS_ISTAT: state_nxt.ist = state_r.ist & ~hwdata_i[NFILT-1:0];
        OFS_IMASK: state_nxt.imask = hwdata_i[NFILT-1:0];
        default:
        begin
          // Region 0 is read only
          if (state_r.a_addr[11:8] == REGION_PAGE &&
              state_r.a_addr[7:4] != 4'h0 &&
              state_r.a_addr[7:4] < 4'(NREG)) // [R03]
          begin
            if (state_r.a_addr[3:2] == FLD_START)
              state_nxt.rstart[state_r.a_addr[7:4]] = hwdata_i; // [R04]
            else if (state_r.a_addr[3:2] == FLD_END)
              state_nxt.rend[state_r.a_addr[7:4]] = hwdata_i; // [R04]
            else if (state_r.a_addr[3:2] == FLD_ATTR)
              state_nxt.rattr[state_r.a_addr[7:4]] =
                hwdata_i & ATTR_MASK; // [R05] [R06] [R07]
          end
        end
      endcase
    end

    // Address phase: latch request, prepare read data
    state_nxt.a_v = 1'b0;
    state_nxt.a_wr = 1'b0;
    if (hsel_i && hready_i && htrans_i == HTRANS_NONSEQ)
    begin
      state_nxt.a_v = 1'b1;
      state_nxt.a_wr = hwrite_i && !hnonsec_i; // [R12]
      state_nxt.a_addr = haddr_i[11:0];
      state_nxt.hrdata = hnonsec_i ? 32'h0000_0000 :
                         reg_read(state_r, haddr_i[11:0]); // [R12]
    end

    for (int f = 0; f < NFILT; f++)
    begin
      state_nxt.rsp_v[f] = 1'b0;
      if (state_r.slot_v[f] && dn_ready_i[f])
        state_nxt.slot_v[f] = 1'b0;
      // Memory responses come back in order and pass unchanged
      if (dn_rsp_valid_i[f])
      begin
        state_nxt.cnt[f] = state_nxt.cnt[f] - CNT_ONE;
        state_nxt.rsp_v[f] = 1'b1;
        state_nxt.rsp_err[f] = 1'b0;
        state_nxt.rsp_rdata[f] = dn_rdata_i[f]; // [R13]
      end
      if (up_fire[f])
      begin
        if (allow[f]) // [R01]
        begin
          state_nxt.slot_v[f] = 1'b1;
          state_nxt.slot_addr[f] = up_addr_i[f]; // [R13]
          state_nxt.slot_wr[f] = up_write_i[f];
          state_nxt.slot_wdata[f] = up_wdata_i[f];
          state_nxt.cnt[f] = state_nxt.cnt[f] + CNT_ONE; // [R10]
        end
        else
        begin
          // Pipe is empty here, so the local answer stays in order
          state_nxt.rsp_v[f] = 1'b1; // [R13]
          state_nxt.rsp_err[f] = state_r.fmode[FM_ERR]; // [R09]
          state_nxt.rsp_rdata[f] = 32'h0000_0000;
          state_nxt.faddr[f] = up_addr_i[f];
          // Set after the clear so a same-cycle event is kept
          if (state_r.fmode[FM_IRQ])
            state_nxt.ist[f] = 1'b1; // [R09]
        end
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_r <= '0;
      state_r.gate <= GATE_RST;
      state_r.fmode <= FMODE_RST;
      state_r.imask <= IMASK_RST;
      state_r.rstart <= {(NREG-1){RBOUND_RST}};
      state_r.rend <= {(NREG-1){RBOUND_RST}};
      state_r.rattr <= {{(NREG-1){RATTR_RST}}, R0_ATTR_RST};
    end
    else
      state_r <= state_nxt;
  end

  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign hrdata_o = state_r.hrdata;
  assign irq_o = |(state_r.ist & state_r.imask);
  assign dn_valid_o = state_r.slot_v;
  assign dn_addr_o = state_r.slot_addr;
  assign dn_write_o = state_r.slot_wr;
  assign dn_wdata_o = state_r.slot_wdata;
  assign up_rsp_valid_o = state_r.rsp_v;
  assign up_rsp_err_o = state_r.rsp_err;
  assign up_rsp_rdata_o = state_r.rsp_rdata;
endmodule

// *** include/dsaf_pkg.sv ***
// Constants, types and permission decode for the DDR secure address filter
package dsaf_pkg;
  localparam int NFILT = 2;
  localparam int NREG = 9;
  localparam int ID_W = 4;
  localparam int CNT_W = 9;
  localparam logic [CNT_W-1:0] MAX_OUTSTANDING = 9'h100;
  localparam logic [CNT_W-1:0] CNT_ONE = 9'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 9'h000;

  // Register byte offsets
  localparam logic [11:0] OFS_GATE = 12'h000;
  localparam logic [11:0] OFS_FMODE = 12'h004;
  localparam logic [11:0] OFS_ISTAT = 12'h008;
  localparam logic [11:0] OFS_IMASK = 12'h00c;
  localparam logic [11:0] OFS_FADDR0 = 12'h010;
  localparam logic [11:0] OFS_FADDR1 = 12'h014;
  localparam logic [11:0] OFS_COUNT = 12'h018;
  // Region block: 0x100 + 0x10 * index, word 0 start, 1 end, 2 attr
  localparam logic [3:0] REGION_PAGE = 4'h1;
  localparam logic [1:0] FLD_START = 2'h0;
  localparam logic [1:0] FLD_END = 2'h1;
  localparam logic [1:0] FLD_ATTR = 2'h2;

  // Attribute field positions
  localparam int ATTR_FILT0 = 0;
  localparam int ATTR_S_RD = 2;
  localparam int ATTR_S_WR = 3;
  localparam int ATTR_NS_RD = 4;
  localparam int ATTR_NS_WR = 5;
  localparam int ATTR_ID_LSB = 16;
  localparam logic [31:0] ATTR_MASK = 32'hffff_003f;

  // Fail mode bits
  localparam int FM_ERR = 0;
  localparam int FM_IRQ = 1;

  // Reset values
  localparam logic [1:0] GATE_RST = 2'h0;
  localparam logic [1:0] FMODE_RST = 2'h1;
  localparam logic [1:0] IMASK_RST = 2'h0;
  localparam logic [31:0] R0_ATTR_RST = 32'h0000_000f;
  localparam logic [31:0] RATTR_RST = 32'h0000_0000;
  localparam logic [31:0] RBOUND_RST = 32'h0000_0000;
  localparam logic [31:0] R0_START = 32'h0000_0000;
  localparam logic [31:0] R0_END = 32'hffff_ffff;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef logic [31:0] dsaf_word_t;

  // Whether a region's attributes let this access through
  function automatic logic dsaf_permit(input dsaf_word_t attr,
                                       input logic write,
                                       input logic nonsec,
                                       input logic [ID_W-1:0] id);
    logic ok;
    ok = 1'b0;
    if (!nonsec)
      ok = write ? attr[ATTR_S_WR] : attr[ATTR_S_RD];
    else
      ok = (write ? attr[ATTR_NS_WR] : attr[ATTR_NS_RD]) &&
           attr[ATTR_ID_LSB + 32'(id)];
    return ok;
  endfunction
endpackage

// *** include/dsaf_cfg_if.sv ***
// Region configuration passed from the register file to the filter checkers
`timescale 1ns/1ps
interface dsaf_cfg_if;
  import dsaf_pkg::*;
  logic [NREG-1:1][31:0] rstart;
  logic [NREG-1:1][31:0] rend;
  logic [NREG-1:0][31:0] rattr;
  modport src (output rstart, output rend, output rattr);
  modport chk (input rstart, input rend, input rattr);
endinterface

// *** rtl/dsaf_check.sv ***
// Region match and permission check for one filter unit
`timescale 1ns/1ps
module dsaf_check #(
  parameter int FILTER = 0
) (
  input wire logic [31:0] addr_i,
  input wire logic write_i,
  input wire logic nonsec_i,
  input wire logic [dsaf_pkg::ID_W-1:0] id_i,
  dsaf_cfg_if.chk cfg,
  output logic allow_o
);
  import dsaf_pkg::*;

  logic [NREG-1:1] hit;

  generate
    for (genvar i = 1; i < NREG; i++)
    begin : g_hit
      // Region counts only on the filters it is attached to
      assign hit[i] = cfg.rattr[i][ATTR_FILT0 + FILTER] && // [R04] [R05]
                      addr_i >= cfg.rstart[i] && addr_i <= cfg.rend[i];
    end
  endgenerate

  // Background region first, a programmable hit overrides it
  always_comb
  begin
    allow_o = dsaf_permit(cfg.rattr[0], write_i, nonsec_i, id_i); // [R03]
    for (int i = 1; i < NREG; i++)
    begin
      if (hit[i])
        allow_o = dsaf_permit(cfg.rattr[i], write_i, nonsec_i, id_i); // [R14] [R06] [R07]
    end
  end
endmodule

// *** testbench/dsaf_mem_model.sv ***
// Memory controller model answering one filter path
`timescale 1ns/1ps
module dsaf_mem_model (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic [31:0] addr_i,
  output logic ready_o,
  output logic rsp_o,
  output logic [31:0] rdata_o
);
  logic [1:0] stall_r;
  logic [2:0] lat_r;
  logic [31:0] addr_r;
  assign ready_o = valid_i && stall_r == 2'h0;
  always_ff @(posedge core_clk_i or posedge reset_i)
    if (reset_i)
    begin
      stall_r <= 2'h3;
      lat_r <= 3'h0;
      addr_r <= 32'h0000_0000;
      rsp_o <= 1'h0;
      rdata_o <= 32'h0000_0000;
    end
    else
    begin
      // One answer per accepted transfer only if the next one waits for it; data toggles when idle
      if (ready_o)
      begin
        lat_r <= 3'h3;
        addr_r <= addr_i;
        stall_r <= slow_i ? 2'h3 : 2'h0;
      end
      else if (valid_i && stall_r != 2'h0)
        stall_r <= stall_r - 2'h1;
      else if (lat_r != 3'h0)
        lat_r <= lat_r - 3'h1;
      rsp_o <= lat_r == 3'h1;
      rdata_o <= lat_r == 3'h1 ? addr_r ^ 32'h5a5a_0000 : ~rdata_o;
    end
endmodule

// *** testbench/dsaf_assertions.sv ***
// Port assertions for the DDR secure address filter
`timescale 1ns/1ps
module dsaf_assertions (
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [1:0] up_valid_i,
  input wire logic [1:0] up_ready_o,
  input wire logic [1:0][31:0] up_addr_i,
  input wire logic [1:0] up_rsp_valid_o,
  input wire logic [1:0] up_rsp_err_o,
  input wire logic [1:0][31:0] up_rsp_rdata_o,
  input wire logic [1:0] dn_valid_o,
  input wire logic [1:0] dn_ready_i,
  input wire logic [1:0][31:0] dn_addr_o,
  input wire logic [1:0] dn_rsp_valid_i
);
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not okay");
  take_first_a: assert property ($rose(dn_valid_o[0]) |->
    $past(up_valid_i[0] && up_ready_o[0]) &&
    dn_addr_o[0] == $past(up_addr_i[0])) else $error("bad forward f0");
  path_one_a: assert property ($rose(dn_valid_o[1]) |->
    $past(up_valid_i[1] && up_ready_o[1]) &&
    dn_addr_o[1] == $past(up_addr_i[1])) else $error("bad forward f1");
  dn_hold_a: assert property (dn_valid_o[0] && !dn_ready_i[0] |=>
    dn_valid_o[0] && $stable(dn_addr_o[0])) else $error("request dropped");
  rsp_follow_a: assert property (dn_rsp_valid_i[0] |=>
    up_rsp_valid_o[0] && !up_rsp_err_o[0]) else $error("answer lost");
  err_nodata_a: assert property (up_rsp_valid_o[0] &&
    up_rsp_err_o[0] |-> up_rsp_rdata_o[0] == 32'h0000_0000)
    else $error("data on refusal");
  rsp_cause_a: assert property (up_rsp_valid_o[1] |->
    $past(up_valid_i[1] && up_ready_o[1]) || $past(dn_rsp_valid_i[1]))
    else $error("answer without cause");
  gate_reset_a: assert property ($fell(reset_i) |-> up_ready_o == 2'h0)
    else $error("filter open after reset");
  cover property (up_rsp_valid_o[0] && up_rsp_err_o[0]);
  cover property (dn_valid_o[0] && !dn_ready_i[0]);
  cover property (dn_valid_o == 2'h3);
endmodule
bind dsaf_top dsaf_assertions chk (.*);

// *** testbench/testbench.sv ***
// Self-checking bench for the DDR secure address filter
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin \
  error_cnt++; $display("unexpected %0t %h %h", $time, a, e); end end
module testbench;
  import dsaf_pkg::*;
  logic core_clk_i, reset_i, hsel_i, hwrite_i, hnonsec_i, slow, irq_o;
  logic hreadyout_o, hresp_o;
  wire logic hready_i;
  logic [1:0] htrans_i, up_valid_i, up_ready_o, up_write_i, up_nonsec_i;
  logic [1:0] up_rsp_valid_o, up_rsp_err_o, dn_valid_o, dn_write_o, fwd;
  logic [2:0] hsize_i;
  logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
  wire logic [1:0] dn_ready_i, dn_rsp_valid_i;
  wire logic [1:0][31:0] dn_rdata_i;
  logic [1:0][31:0] up_addr_i, up_wdata_i, up_rsp_rdata_o;
  logic [1:0][31:0] dn_addr_o, dn_wdata_o, wd;
  logic [1:0][3:0] up_id_i;
  int error_cnt, samples_checked;
  assign hready_i = hreadyout_o;
  dsaf_top dut (.*);
  for (genvar f = 0; f < 2; f++)
  begin : g_mem
    dsaf_mem_model mem (.core_clk_i, .reset_i, .slow_i(slow),
      .valid_i(dn_valid_o[f]), .addr_i(dn_addr_o[f]),
      .ready_o(dn_ready_i[f]), .rsp_o(dn_rsp_valid_i[f]),
      .rdata_o(dn_rdata_i[f]));
  end
  initial
  begin
    core_clk_i = 1'h0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i)
    for (int f = 0; f < 2; f++)
      if (dn_valid_o[f] === 1'h1)
      begin
        fwd[f] = 1'h1;
        wd[f] = dn_wdata_o[f];
      end
  task automatic tally_and_finish;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic await(input int k, f);
    int n;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end
    while ((k == 0 ? hready_i : k == 1 ? up_ready_o[f] : up_rsp_valid_o[f])
           !== 1'h1 && n < 100);
    if (n >= 100)
    begin
      error_cnt++;
      tally_and_finish;
    end
  endtask
  task automatic ahb(input logic [11:0] a, input logic w, ns,
                     input logic [31:0] d);
    hsel_i <= 1'h1;
    haddr_i <= {20'h0_0000, a};
    htrans_i <= HTRANS_NONSEQ;
    hwrite_i <= w;
    hnonsec_i <= ns;
    await(0, 0);
    hsel_i <= 1'h0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    await(0, 0);
    rd = hrdata_o;
  endtask
  task automatic acc(input int f, input logic [15:0] a, input logic w, ns,
                     input logic [3:0] id, input logic ok, err);
    fwd[f] = 1'h0;
    up_valid_i[f] <= 1'h1;
    up_addr_i[f] <= {16'h0000, a};
    up_write_i[f] <= w;
    up_nonsec_i[f] <= ns;
    up_id_i[f] <= id;
    up_wdata_i[f] <= {a, ~a};
    await(1, f);
    up_valid_i[f] <= 1'h0;
    await(2, f);
    `CHK(fwd[f], ok)
    `CHK(up_rsp_err_o[f], err)
    if (ok && w)
      `CHK(wd[f], {a, ~a})
    else
      `CHK(up_rsp_rdata_o[f], ok ? {16'h5a5a, a} : 32'h0000_0000)
  endtask
  task automatic t_reset_vals;
    `CHK(up_ready_o, 2'h0)
    ahb(OFS_FMODE, 0, 0, 0);
    `CHK(rd[1:0], FMODE_RST)
    ahb(12'h104, 0, 0, 0);
    `CHK(rd, R0_END)
  endtask
  task automatic t_config_guard;
    ahb(OFS_GATE, 1, 1, 32'h0000_0003);
    ahb(OFS_GATE, 0, 0, 0);
    `CHK(rd, 32'h0000_0000)
    ahb(12'h108, 1, 0, 32'h0000_0000);
    ahb(12'h108, 0, 0, 0);
    `CHK(rd, R0_ATTR_RST)
    ahb(12'h0f0, 1, 0, 32'hffff_ffff);
    ahb(12'h0f0, 0, 0, 0);
    `CHK(rd, 32'h0000_0000)
  endtask
  task automatic t_regions;
    ahb(OFS_GATE, 1, 0, 32'h0000_0003);
    ahb(12'h110, 1, 0, 32'h0000_1000);
    ahb(12'h114, 1, 0, 32'h0000_1fff);
    ahb(12'h118, 1, 0, 32'h0008_0011);
    ahb(12'h120, 1, 0, 32'h0000_4000);
    ahb(12'h124, 1, 0, 32'h0000_4fff);
    ahb(12'h128, 1, 0, 32'h0020_0022);
    acc(0, 16'h8000, 0, 0, 0, 1, 0);
    acc(0, 16'h8000, 0, 1, 3, 0, 1);
    acc(0, 16'h1000, 0, 1, 3, 1, 0);
    acc(0, 16'h1fff, 0, 1, 3, 1, 0);
    acc(0, 16'h2000, 0, 1, 3, 0, 1);
    acc(0, 16'h1800, 0, 1, 2, 0, 1);
    slow = 1'h1;
    acc(0, 16'h1800, 1, 1, 3, 0, 1);
    acc(0, 16'h1800, 0, 0, 0, 0, 1);
    acc(1, 16'h1800, 0, 1, 3, 0, 1);
    acc(1, 16'h4800, 1, 1, 5, 1, 0);
    acc(0, 16'h4800, 1, 1, 5, 0, 1);
    fork acc(0, 16'h8000, 1, 0, 0, 1, 0); acc(1, 16'h9000, 1, 0, 0, 1, 0); join
  endtask
  task automatic t_fail_modes;
    ahb(OFS_IMASK, 1, 0, 32'h0000_0001);
    ahb(OFS_FMODE, 1, 0, 32'h0000_0002);
    acc(0, 16'h9000, 0, 1, 3, 0, 0);
    `CHK(irq_o, 1'h1)
    ahb(OFS_FADDR0, 0, 0, 0);
    `CHK(rd, 32'h0000_9000)
    ahb(OFS_ISTAT, 1, 0, 32'h0000_0001);
    ahb(OFS_FMODE, 1, 0, 32'h0000_0003);
    `CHK(irq_o, 1'h0)
    acc(1, 16'h9000, 0, 1, 3, 0, 1);
    `CHK(irq_o, 1'h0)
    ahb(OFS_ISTAT, 0, 0, 0);
    `CHK(rd, 32'h0000_0002)
    ahb(OFS_COUNT, 0, 0, 0);
    `CHK(rd, 32'h0000_0000)
  endtask
  task automatic t_gate;
    ahb(OFS_GATE, 1, 0, 32'h0000_0002);
    up_valid_i[0] <= 1'h1;
    repeat (8)
    begin
      @(posedge core_clk_i);
      `CHK(up_ready_o[0], 1'h0)
    end
    up_valid_i[0] <= 1'h0;
    acc(1, 16'h8000, 0, 0, 0, 1, 0);
  endtask
  initial
  begin
    error_cnt = 0;
    samples_checked = 0;
    slow = 1'h0;
    reset_i = 1'h1;
    {hsel_i, hwrite_i, hnonsec_i, htrans_i, haddr_i, hwdata_i} = '0;
    hsize_i = 3'h2;
    {up_valid_i, up_write_i, up_nonsec_i, up_id_i, up_addr_i} = '0;
    up_wdata_i = '0;
    repeat (16) @(posedge core_clk_i);
    reset_i <= 1'h0;
    t_reset_vals;
    t_config_guard;
    t_regions;
    t_fail_modes;
    t_gate;
    tally_and_finish;
  end
endmodule
